// ==== hdl/ccpc_hyst.sv ====
// Hysteresis decrementer of one coil chopper.
// Assumes a one-cycle load pulse at every chopper cycle start.
`timescale 1ns/1ps
`default_nettype none
`include "ccpc_map.svh"

module ccpc_hyst
(
   input  wire logic                  mclk_i,
   input  wire logic                  reset_i,
   input  wire logic                  load_i,
   input  wire logic [2:0]            hyst_start_i,
   input  wire logic [3:0]            hyst_end_i,
   output var  ccpc_pkg::ccpc_offset_t hyst_o
);
   import ccpc_pkg::*;

   ccpc_offset_t hyst_reg;
   ccpc_offset_t hyst_next;
   logic [3:0]   pre_reg;
   logic [3:0]   pre_next;

   wire ccpc_offset_t end_val;
   wire ccpc_offset_t start_val;
   wire               step_due;

   assign end_val   = ccpc_offset_t'({2'b00, hyst_end_i}) - 6'(`CCPC_HYSTERESIS_END_BIAS);
   assign start_val = ccpc_offset_t'({3'b000, hyst_start_i}) + 6'sd1 + end_val;
   assign step_due  = pre_reg == 4'(`CCPC_HYSTERESIS_DECREMENTER_PERIOD - 1);

   always_comb
   begin
      hyst_next = hyst_reg;
      pre_next  = pre_reg + 4'h1;
      if (load_i)
      begin
         hyst_next = start_val;
         pre_next  = 4'h0;
      end
      else if (step_due && (hyst_reg > end_val))
      begin
         hyst_next = hyst_reg - 6'sd1;
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         hyst_reg <= '0;
         pre_reg  <= 4'h0;
      end
      else
      begin
         hyst_reg <= hyst_next;
         pre_reg  <= pre_next;
      end
   end

   assign hyst_o = hyst_reg;

endmodule
`default_nettype wire

// ==== hdl/ccpc_top.sv ====
// Coil chopper phase control: one independent chopper per coil, configured
// over a plain register port.
// Assumes a comparator per coil that reports |current| >= target + offset,
// and a reverse-current flag during fast decay, both synchronous to mclk_i.
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ccpc_map.svh"

module ccpc_top
#(
   parameter int NCOIL = 2
)
(
   input  wire logic                   mclk_i,
   input  wire logic                   reset_i,
   input  wire logic [7:0]             reg_addr_i,
   input  wire logic [31:0]            reg_wdata_i,
   input  wire logic                   reg_wr_i,
   input  wire logic                   reg_rd_i,
   output var  logic [31:0]            reg_rdata_o,
   input  wire logic [NCOIL-1:0]       cmp_reached_i,
   input  wire logic [NCOIL-1:0]       cmp_reverse_i,
   input  wire logic [NCOIL-1:0]       fullstep_load_i,
   output var  logic [NCOIL-1:0][2:0]  bridge_phase_o,
   output var  logic [NCOIL-1:0][5:0]  cmp_offset_o
);
   import ccpc_pkg::*;

   // Register map holds four coils per bank before banks would overlap
   if (NCOIL < 1 || NCOIL > 4)
   begin : g_bad_ncoil
      $error("ccpc_top: NCOIL must be 1 to 4");
   end

   function automatic logic [5:0] blank_clocks(input logic [1:0] sel);
      logic [5:0] n;
      n = 6'(`CCPC_BLANK0);
      unique case (sel)
         2'b00: n = 6'(`CCPC_BLANK0);
         2'b01: n = 6'(`CCPC_BLANK1);
         2'b10: n = 6'(`CCPC_BLANK2);
         2'b11: n = 6'(`CCPC_BLANK3);
      endcase
      return n;
   endfunction

   logic [NCOIL-1:0][31:0] rd_word;
   logic [31:0]            rdata_reg;
   logic [31:0]            rdata_next;

   for (genvar c = 0; c < NCOIL; c++)
   begin : g_coil
      // Live configuration written by software, and the copy the cycle runs on
      logic [`CCPC_CFG_W-1:0] cfg_reg;
      logic [`CCPC_CFG_W-1:0] act_reg;
      logic                   cot_reg;
      ccpc_phase_t            ph_reg;
      ccpc_phase_t            ph_next;
      logic [9:0]             tmr_reg;
      logic [9:0]             tmr_next;
      logic [5:0]             blk_reg;
      logic [5:0]             blk_next;
      logic [15:0]            cyc_reg;
      ccpc_offset_t           off_reg;
      ccpc_offset_t           off_next;
      logic                   load_cyc;

      wire ccpc_offset_t hyst;
      wire               cfg_hit;
      wire               stat_hit;
      wire               cnt_hit;
      wire               cfg_wr;
      wire [3:0]         live_sdt;
      wire [1:0]         live_blank;
      wire               live_cot;
      wire [3:0]         act_sdt;
      wire [2:0]         act_hstart;
      wire [3:0]         act_hysteresis_end;
      wire [1:0]         act_blank;
      wire               act_fdcmp_dis;
      wire [3:0]         fd_code;
      wire [9:0]         slow_len;
      wire [9:0]         fast_len;
      wire               blk_done;
      wire               tmr_done;
      wire               on_end;
      wire               fast_end;
      wire [2:0]         hyst_start_sel;
      wire [3:0]         hyst_end_sel;
      wire ccpc_offset_t sine_off;
      wire [31:0]        stat_word;

      assign cfg_hit  = reg_addr_i == 8'(`CCPC_CFG_OFS + c * `CCPC_OFS_STEP);
      assign stat_hit = reg_addr_i == 8'(`CCPC_STAT_OFS + c * `CCPC_OFS_STEP);
      assign cnt_hit  = reg_addr_i == 8'(`CCPC_CNT_OFS + c * `CCPC_OFS_STEP);
      assign cfg_wr   = reg_wr_i && cfg_hit;

      assign live_sdt   = cfg_reg[`CCPC_SDT_LSB +: 4];
      assign live_blank = cfg_reg[`CCPC_BLANK_LSB +: 2];
      assign live_cot   = cfg_reg[`CCPC_CHOP_MODE_BIT] | fullstep_load_i[c];

      assign act_sdt       = act_reg[`CCPC_SDT_LSB +: 4];
      assign act_hstart    = act_reg[`CCPC_HSTART_LSB +: 3];
      assign act_hysteresis_end      = act_reg[`CCPC_HYSTERESIS_END_LSB +: 4];
      assign act_blank     = act_reg[`CCPC_BLANK_LSB +: 2];
      assign act_fdcmp_dis = act_reg[`CCPC_FDCMP_DIS_BIT];
      assign fd_code       = {act_reg[`CCPC_FDTOP_BIT], act_hstart};

      assign slow_len = 10'(`CCPC_SLOW_BASE) + 10'(`CCPC_SLOW_STEP) * 10'(act_sdt);
      assign fast_len = 10'(`CCPC_FAST_STEP) * 10'(fd_code);

      assign blk_done = blk_reg == 6'h00;
      assign tmr_done = tmr_reg == 10'h000;
      assign on_end   = blk_done && cmp_reached_i[c];
      // Off-time mode: time out, or reverse current once blanking is over
      assign fast_end = cot_reg
                        ? (tmr_done || (!act_fdcmp_dis && blk_done && cmp_reverse_i[c]))
                        : (blk_done && !cmp_reached_i[c]);

      // The decrementer samples the incoming configuration on the load edge
      assign hyst_start_sel = load_cyc ? cfg_reg[`CCPC_HSTART_LSB +: 3] : act_hstart;
      assign hyst_end_sel   = load_cyc ? cfg_reg[`CCPC_HYSTERESIS_END_LSB +: 4] : act_hysteresis_end;

      assign sine_off = ccpc_offset_t'({2'b00, act_hysteresis_end}) - 6'(`CCPC_HYSTERESIS_END_BIAS);

      ccpc_hyst u_hyst
      (
         .mclk_i       (mclk_i),
         .reset_i      (reset_i),
         .load_i       (load_cyc),
         .hyst_start_i (hyst_start_sel),
         .hyst_end_i   (hyst_end_sel),
         .hyst_o       (hyst)
      );

      always_comb
      begin
         ph_next  = ph_reg;
         tmr_next = tmr_done ? 10'h000 : tmr_reg - 10'h001;
         blk_next = blk_done ? 6'h00 : blk_reg - 6'h01;
         load_cyc = 1'b0;
         unique case (ph_reg)
            PH_OFF:
            begin
               if (live_sdt != 4'h0)
               begin
                  ph_next  = PH_ON;
                  blk_next = blank_clocks(live_blank);
                  load_cyc = 1'b1;
               end
            end
            PH_ON:
            begin
               if (on_end)
               begin
                  if (!cot_reg)
                  begin
                     ph_next  = PH_SLOW1;
                     tmr_next = slow_len - 10'h001;
                  end
                  else if (fd_code != 4'h0)
                  begin
                     ph_next  = PH_FAST;
                     tmr_next = fast_len - 10'h001;
                     blk_next = blank_clocks(act_blank);
                  end
                  else
                  begin
                     ph_next  = PH_SLOW2;
                     tmr_next = slow_len - 10'h001;
                  end
               end
            end
            PH_SLOW1:
            begin
               if (tmr_done)
               begin
                  ph_next  = PH_FAST;
                  blk_next = blank_clocks(act_blank);
               end
            end
            PH_FAST:
            begin
               if (fast_end)
               begin
                  ph_next  = PH_SLOW2;
                  tmr_next = slow_len - 10'h001;
               end
            end
            PH_SLOW2:
            begin
               if (tmr_done)
               begin
                  // Cycle boundary: a cleared slow decay time frees the coil
                  if (live_sdt == 4'h0)
                  begin
                     ph_next = PH_OFF;
                  end
                  else
                  begin
                     ph_next  = PH_ON;
                     blk_next = blank_clocks(live_blank);
                     load_cyc = 1'b1;
                  end
               end
            end
            default:
            begin
               ph_next = PH_OFF;
            end
         endcase
      end

      // Hysteresis mode lowers the threshold by the hysteresis in fast decay
      always_comb
      begin
         if (cot_reg)
         begin
            off_next = sine_off;
         end
         else if (ph_reg == PH_FAST)
         begin
            off_next = -hyst;
         end
         else
         begin
            off_next = hyst;
         end
      end

      always_ff @(posedge mclk_i)
      begin
         if (reset_i)
         begin
            cfg_reg <= `CCPC_CFG_RST;
         end
         else if (cfg_wr)
         begin
            cfg_reg <= reg_wdata_i[`CCPC_CFG_W-1:0];
         end
      end

      // Latching at the cycle start keeps a running phase from being cut short
      always_ff @(posedge mclk_i)
      begin
         if (reset_i)
         begin
            act_reg <= `CCPC_CFG_RST;
            cot_reg <= 1'b0;
         end
         else if (load_cyc)
         begin
            act_reg <= cfg_reg;
            cot_reg <= live_cot;
         end
      end

      always_ff @(posedge mclk_i)
      begin
         if (reset_i)
         begin
            ph_reg  <= PH_OFF;
            tmr_reg <= 10'h000;
            blk_reg <= 6'h00;
            off_reg <= '0;
         end
         else
         begin
            ph_reg  <= ph_next;
            tmr_reg <= tmr_next;
            blk_reg <= blk_next;
            off_reg <= off_next;
         end
      end

      // Chopper cycle counter wraps; software takes differences
      always_ff @(posedge mclk_i)
      begin
         if (reset_i)
         begin
            cyc_reg <= 16'h0000;
         end
         else if (load_cyc)
         begin
            cyc_reg <= cyc_reg + 16'h0001;
         end
      end

      assign stat_word = {16'h0000,
                          2'b00, off_reg,
                          3'b000, cot_reg,
                          1'b0, ph_reg};

      assign rd_word[c] = cfg_hit  ? {16'h0000, cfg_reg} :
                          stat_hit ? stat_word :
                          cnt_hit  ? {16'h0000, cyc_reg} :
                          32'h0000_0000;

      assign bridge_phase_o[c] = ph_reg;
      assign cmp_offset_o[c]   = off_reg;
   end

   // Unmapped addresses answer zero; data stand only in the cycle after the read
   always_comb
   begin
      rdata_next = 32'h0000_0000;
      for (int i = 0; i < NCOIL; i++)
      begin
         rdata_next = rdata_next | rd_word[i];
      end
      if (!reg_rd_i)
      begin
         rdata_next = 32'h0000_0000;
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         rdata_reg <= 32'h0000_0000;
      end
      else
      begin
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata_o = rdata_reg;

endmodule
`default_nettype wire

// ==== shared/ccpc_map.svh ====
// Register offsets, configuration field positions, reset values and timing
// counts of the coil chopper phase control block.
// Assumes it is included by bare name; definitions only.
`ifndef CCPC_MAP_SVH
`define CCPC_MAP_SVH

// Register byte offsets; coil c sits at base + 4*c
`define CCPC_CFG_OFS         8'h00
`define CCPC_STAT_OFS        8'h10
`define CCPC_CNT_OFS         8'h20
`define CCPC_OFS_STEP        8'h04

// Configuration field positions
`define CCPC_SDT_LSB         0
`define CCPC_HSTART_LSB      4
`define CCPC_HYSTERESIS_END_LSB        7
`define CCPC_FDTOP_BIT       11
`define CCPC_FDCMP_DIS_BIT   12
`define CCPC_CHOP_MODE_BIT   13
`define CCPC_BLANK_LSB       14
`define CCPC_CFG_W           16

// Status field positions
`define CCPC_ST_PHASE_LSB    0
`define CCPC_ST_COT_BIT      4
`define CCPC_ST_HYST_LSB     8

// Reset values
`define CCPC_CFG_RST         16'h0000

// Timing counts in system clocks, and the hysteresis end bias
`define CCPC_SLOW_BASE       12
`define CCPC_SLOW_STEP       32
`define CCPC_FAST_STEP       32
`define CCPC_BLANK0          16
`define CCPC_BLANK1          24
`define CCPC_BLANK2          36
`define CCPC_BLANK3          54
`define CCPC_HYSTERESIS_DECREMENTER_PERIOD     16
`define CCPC_HYSTERESIS_END_BIAS       3

`endif

// ==== shared/ccpc_pkg.sv ====
// Types shared by the coil chopper phase control block.
// Assumes nothing of its surroundings.
package ccpc_pkg;

   // Chopper phase, also the bridge command driven to the power stage
   typedef enum logic [2:0] {
      PH_OFF   = 3'b000,
      PH_ON    = 3'b001,
      PH_SLOW1 = 3'b010,
      PH_FAST  = 3'b011,
      PH_SLOW2 = 3'b100
   } ccpc_phase_t;

   // Signed comparator threshold offset and hysteresis value
   typedef logic signed [5:0] ccpc_offset_t;

endpackage

// ==== verification/ccpc_checker_asserts.sv ====
// Port checker of the chopper block; coil 0 is watched.
// Assumes it is bound into ccpc_top.
`timescale 1ns/1ps
`default_nettype none
module ccpc_checker
#(
   parameter int NCOIL = 2
)
(
   input wire logic                  mclk_i,
   input wire logic                  reset_i,
   input wire logic [7:0]            reg_addr_i,
   input wire logic [31:0]           reg_wdata_i,
   input wire logic                  reg_wr_i,
   input wire logic                  reg_rd_i,
   input wire logic [31:0]           reg_rdata_o,
   input wire logic [NCOIL-1:0]      cmp_reached_i,
   input wire logic [NCOIL-1:0]      cmp_reverse_i,
   input wire logic [NCOIL-1:0]      fullstep_load_i,
   input wire logic [NCOIL-1:0][2:0] bridge_phase_o,
   input wire logic [NCOIL-1:0][5:0] cmp_offset_o
);
   import ccpc_pkg::*;
   wire logic [2:0] ph = bridge_phase_o[0];
   wire logic [5:0] ofs = cmp_offset_o[0];
   logic [2:0]      last_reg;
   int              run_reg;
   wire logic       chg = ph != last_reg;
   // Length of the phase just left; saturates so it never wraps
   always_ff @(posedge mclk_i)
   begin
      last_reg <= reset_i ? 3'h0 : ph;
      run_reg <= (reset_i || chg) ? 1 : (run_reg < 4000 ? run_reg + 1 : run_reg);
   end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   a_rd_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0000_0000)
      else $error("read data not idle");
   a_slow1_next: assert property (chg && last_reg == PH_SLOW1 |-> ph == PH_FAST)
      else $error("slow decay 1 not followed by fast decay");
   a_fast_next: assert property (chg && last_reg == PH_FAST |-> ph == PH_SLOW2)
      else $error("fast decay not followed by slow decay 2");
   a_slow2_next: assert property (chg && last_reg == PH_SLOW2 |-> ph inside {PH_ON, PH_OFF})
      else $error("slow decay 2 left wrongly");
   a_on_next: assert property (chg && last_reg == PH_ON
      |-> ph inside {PH_SLOW1, PH_FAST, PH_SLOW2})
      else $error("on phase left wrongly");
   a_blank_min: assert property (chg && last_reg inside {PH_ON, PH_FAST}
      |-> run_reg >= 16)
      else $error("phase ended inside blanking");
   a_slow_len: assert property (chg && last_reg inside {PH_SLOW1, PH_SLOW2}
      |-> run_reg % 32 == 12)
      else $error("slow decay length off grid");
   a_hyst_step: assert property (ph inside {PH_ON, PH_SLOW1, PH_SLOW2} && $stable(ph)
      && ph == $past(ph, 2) && ph == $past(ph, 3) && ph == $past(ph, 4)
      |-> ofs == $past(ofs) || ofs == $past(ofs) - 6'h01)
      else $error("hysteresis step too large");
   c_on_slow1: cover property (chg && last_reg == PH_ON && ph == PH_SLOW1);
   c_on_fast: cover property (chg && last_reg == PH_ON && ph == PH_FAST);
   c_on_slow2: cover property (chg && last_reg == PH_ON && ph == PH_SLOW2);
   c_stop: cover property (chg && last_reg == PH_SLOW2 && ph == PH_OFF);
endmodule
bind ccpc_top ccpc_checker #(.NCOIL(NCOIL)) i_chk (.mclk_i(mclk_i), .reset_i(reset_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .cmp_reached_i(cmp_reached_i),
   .cmp_reverse_i(cmp_reverse_i), .fullstep_load_i(fullstep_load_i),
   .bridge_phase_o(bridge_phase_o), .cmp_offset_o(cmp_offset_o));
`default_nettype wire

// ==== verification/ccpc_coil_model.sv ====
// Behavioural coil bridge and sense comparator for one coil.
// Assumes phase and offset come straight from the chopper on mclk_i.
`timescale 1ns/1ps
`default_nettype none
module ccpc_coil_model
#(
   parameter int TGT = 40
)
(
   input  wire logic       mclk_i,
   input  wire logic       reset_i,
   input  wire logic [2:0] phase_i,
   input  wire logic [5:0] offset_i,
   input  wire logic [2:0] rate_i,
   output logic            reached_o,
   output logic            reverse_o
);
   int cur;
   // Rises at rate_i when on, falls fast in fast decay, holds in slow decay
   always @(posedge mclk_i)
   begin
      if (reset_i || phase_i == 3'h0)
         cur <= 0;
      else if (phase_i == 3'h1)
         cur <= cur + int'(rate_i);
      else if (phase_i == 3'h3)
         cur <= cur - 2;
   end
   assign reached_o = cur >= TGT + int'($signed(offset_i));
   assign reverse_o = cur <= -TGT;
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench of the coil chopper phase control block.
// Assumes two coils, each closed by its own bridge model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
   $display("MISMATCH %s exp %0d got %0d", n, e, g); end end
module tb;
   import ccpc_pkg::*;
   logic                 mclk_i = 0;
   logic                 reset_i = 1;
   logic [7:0]           reg_addr_i = 0;
   logic [31:0]          reg_wdata_i = 0;
   logic                 reg_wr_i = 0;
   logic                 reg_rd_i = 0;
   logic [1:0]           fullstep_load_i = 0;
   logic [1:0][2:0]      rate = {3'h4, 3'h4};
   wire logic [31:0]     reg_rdata_o;
   wire logic [1:0]      cmp_reached_i, cmp_reverse_i;
   wire logic [1:0][2:0] bridge_phase_o;
   wire logic [1:0][5:0] cmp_offset_o;
   int                   num_errors = 0, checks_done = 0, cyc = 0;
   int                   ev_n[2], run[2], ev_len[2][256];
   logic [2:0]           lph[2], ev_ph[2][256];
   logic [5:0]           o3[2], ev_o3[2][256], ev_oe[2][256];

   ccpc_top i_dut (.mclk_i(mclk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .cmp_reached_i(cmp_reached_i),
      .cmp_reverse_i(cmp_reverse_i), .fullstep_load_i(fullstep_load_i),
      .bridge_phase_o(bridge_phase_o), .cmp_offset_o(cmp_offset_o));
   for (genvar g = 0; g < 2; g++)
   begin : g_m
      ccpc_coil_model i_m (.mclk_i(mclk_i), .reset_i(reset_i), .phase_i(bridge_phase_o[g]),
         .offset_i(cmp_offset_o[g]), .rate_i(rate[g]), .reached_o(cmp_reached_i[g]),
         .reverse_o(cmp_reverse_i[g]));
   end

   always #5 mclk_i = ~mclk_i;

   // Phase log on the falling edge, where outputs have settled
   always @(negedge mclk_i)
   begin
      for (int c = 0; c < 2; c++)
      begin
         if (bridge_phase_o[c] !== lph[c])
         begin
            if (ev_n[c] < 256)
            begin
               ev_ph[c][ev_n[c]] = lph[c];
               ev_len[c][ev_n[c]] = run[c];
               ev_o3[c][ev_n[c]] = o3[c];
               ev_oe[c][ev_n[c]] = cmp_offset_o[c];
               ev_n[c]++;
            end
            run[c] = 0;
         end
         run[c]++;
         if (run[c] == 4)
            o3[c] = cmp_offset_o[c];
         lph[c] = bridge_phase_o[c];
      end
   end

   task automatic give_verdict();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   always @(posedge mclk_i)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         num_errors++;
         give_verdict();
      end
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      reg_wr_i <= 1'h1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge mclk_i);
      reg_wr_i <= 1'h0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk_i);
      reg_rd_i <= 1'h1;
      reg_addr_i <= a;
      @(posedge mclk_i);
      reg_rd_i <= 1'h0;
      #1 d = reg_rdata_o;
   endtask

   // Write a coil setup, then restart its log once the new value is in the register
   task automatic go(input int c, cot, sdt, hs, he, top, fdis, bl);
      wr(8'(4 * c), 32'(sdt + hs * 16 + he * 128 + top * 2048 + fdis * 4096
         + cot * 8192 + bl * 16384));
      @(posedge mclk_i);
      ev_n[c] = 0;
   endtask

   task automatic settle();
      for (int n = 0; n < 8000 && (ev_n[0] < 10 || ev_n[1] < 10); n++)
         @(posedge mclk_i);
   endtask

   // Reference sequence: events before the first fresh on phase use the old setup
   task automatic chk(input int c, cot, sdt, hs, he, top, fdis, bl, osdt);
      int         k, s, ln, fc, b;
      logic [2:0] p, e;
      s = 0;
      e = PH_ON;
      fc = top * 8 + hs;
      b = (bl == 0) ? 16 : (bl == 1) ? 24 : (bl == 2) ? 36 : 54;
      for (k = 0; k < ev_n[c]; k++)
      begin
         p = ev_ph[c][k];
         ln = ev_len[c][k];
         if (s == 0 && !(p == PH_ON && k > 0))
         begin
            if (p inside {PH_SLOW1, PH_SLOW2} && osdt > 0)
               `CHK("old slow", 12 + 32 * osdt, ln)
            continue;
         end
         s++;
         `CHK("phase order", e, p)
         if (p inside {PH_SLOW1, PH_SLOW2})
            `CHK("slow len", 12 + 32 * sdt, ln)
         if (p == PH_ON || (p == PH_FAST && !(cot && fdis)))
            `CHK("blanked", 1, int'(ln >= b))
         if (p == PH_FAST && cot)
            `CHK("fast len", 1, int'(fdis ? ln == 32 * fc : ln < 32 * fc))
         if (p == PH_ON)
            `CHK("start ofs", 6'(cot ? he - 3 : hs + he - 2), ev_o3[c][k])
         if (p == PH_ON && !cot && rate[c] == 3'h4)
            `CHK("on len", 1, int'(ln <= b + 2))
         if (p == PH_SLOW1 && ev_len[c][k - 1] + ln > 16 * (hs + 1) + 4)
            `CHK("end hyst", 6'(he - 3), ev_oe[c][k])
         // Fast decay threshold sits below target by the settled end hysteresis
         if (p == PH_FAST && !cot && ev_len[c][k - 2] + ev_len[c][k - 1] > 16 * hs + 20)
            `CHK("fast hyst", 6'(3 - he), ev_oe[c][k])
         e = (p == PH_SLOW2) ? PH_ON : (p == PH_SLOW1) ? PH_FAST : (p == PH_FAST) ? PH_SLOW2
            : (cot && fc == 0) ? PH_SLOW2 : cot ? PH_FAST : PH_SLOW1;
      end
      `CHK("cycles seen", 1, int'(s >= 3))
   endtask

   initial
   begin
      logic [31:0] d, w;
      int          b, hs, he, n;
      w = $urandom(97);
      repeat (20) @(posedge mclk_i);
      reset_i <= 1'h0;
      for (b = 0; b < 7; b++)
      begin
         rd(8'(b / 2 * 16 + b % 2 * 4), d);
         `CHK("reset reg", 32'h0000_0000, d)
      end
      wr(8'h30, 32'hFFFF_FFFF);
      rd(8'h30, d);
      `CHK("unmapped", 32'h0000_0000, d)
      w = $urandom & 32'hFFFF_FFF0;
      wr(8'h04, w);
      rd(8'h04, d);
      `CHK("cfg readback", w & 32'h0000_FFFF, d)
      `CHK("coil stopped", 3'h0, bridge_phase_o[1])
      wr(8'h04, 32'h0000_0000);
      for (b = 0; b < 4; b++)
      begin
         hs = $urandom % 8;
         he = $urandom % 16;
         if (hs + he > 18)
            he = 18 - hs;
         rate[1] <= 3'(1 + $urandom % 4);
         go(0, 0, b + 1, hs, he, 0, 0, b);
         go(1, 1, 4 - b, b + 1, he, 0, 1, 3 - b);
         settle();
         chk(0, 0, b + 1, hs, he, 0, 0, b, b);
         chk(1, 1, 4 - b, b + 1, he, 0, 1, 3 - b, b > 0 ? 5 - b : 0);
      end
      go(0, 1, 2, 0, 5, 0, 1, 2);
      go(1, 1, 1, 7, 4, 1, 0, 0);
      settle();
      chk(0, 1, 2, 0, 5, 0, 1, 2, 4);
      chk(1, 1, 1, 7, 4, 1, 0, 0, 1);
      fullstep_load_i <= 2'h1;
      go(0, 0, 1, 2, 3, 0, 1, 1);
      settle();
      chk(0, 1, 1, 2, 3, 0, 1, 1, 2);
      rd(8'h10, d);
      `CHK("off-time flag", 1'h1, d[4])
      fullstep_load_i <= 2'h0;
      go(0, 0, 0, 0, 0, 0, 0, 0);
      for (n = 0; n < 3000 && bridge_phase_o[0] !== 3'h0; n++)
         @(posedge mclk_i);
      repeat (50) @(posedge mclk_i);
      `CHK("free wheel", 3'h0, bridge_phase_o[0])
      reset_i <= 1'h1;
      repeat (20) @(posedge mclk_i);
      reset_i <= 1'h0;
      @(posedge mclk_i);
      #1 `CHK("reset phase", 6'h00, {bridge_phase_o[1], bridge_phase_o[0]})
      `CHK("reset offset", 12'h000, cmp_offset_o)
      // A fresh start from off opens exactly one chopper cycle
      wr(8'h00, 32'h0000_0001);
      rd(8'h20, d);
      `CHK("cycle count", 32'h0000_0001, d)
      give_verdict();
   end
endmodule
`default_nettype wire
